// >>> src/mwd_pkg.sv
// Constants and carrier types for the serial-slave write/diagnosis handler.
// Assumes a framing layer on the same clock that delivers one PDU as a byte stream.
// Behaviour
// RL1 - Function 0x42 writes 1 to 16 consecutive registers from the given start address.
// RL2 - A 0x42 request carries a byte count of twice the register count, then two bytes per value.
// RL3 - A good 0x42 answer echoes only function code, start address and register count.
// RL4 - A 0x42 write to a stop-only parameter is answered with exception code 1.
// RL5 - A 0x08 request and its answer carry a two-byte sub-function and a two-byte data field.
// RL6 - Diagnosis requests never read or change any parameter or discrete value.
// RL7 - Sub-function 0000 returns the request unchanged.
// RL8 - A communication error counter is kept and can be cleared by a diagnosis request.
// RL9 - Function 0x06 writes one holding register from a two-byte address and a two-byte value.
// RL10 - The single-write answer leaves only after the register is updated and echoes the request.
// RL11 - The master should avoid the saving single write for often-changed parameters.
// RL12 - Function 0x41 behaves like 0x06 but updates only the RAM copy, never non-volatile memory.
// RL13 - A non-saved value acts at once and the stored value returns after the next power-up.
// RL14 - The master is advised to use the non-saving write for often-changed values.
// RL15 - A failed request is answered with function code plus 0x80 and a one-byte exception code.
// RL16 - Every 16-bit address or value travels high byte first.
// RL17 - A 0x42 request with bad register or byte count is refused without any write.
package mwd_pkg;

    localparam logic [7:0]  FN_WR_SAVE   = 8'h06;
    localparam logic [7:0]  FN_DIAG      = 8'h08;
    localparam logic [7:0]  FN_WR_RAM    = 8'h41;
    localparam logic [7:0]  FN_WR_MULTI  = 8'h42;
    localparam logic [7:0]  FN_ERR_FLAG  = 8'h80;

    localparam logic [7:0]  EXC_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_DATA     = 8'h03;

    localparam logic [15:0] DIAG_ECHO    = 16'h0000;
    localparam logic [15:0] DIAG_CLR_CNT = 16'h000a;

    localparam logic [15:0] REG_MIN      = 16'h0001;
    localparam logic [15:0] REG_MAX      = 16'h0010;

    localparam logic [2:0]  HDR_LAST     = 3'h3;
    localparam logic [2:0]  RSP_LEN_OK   = 3'h5;
    localparam logic [2:0]  RSP_LEN_ERR  = 3'h2;

    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] CNT_TOP      = 16'hffff;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } mwd_byte_t;

    typedef struct packed {
        logic        valid;
        logic        save;
        logic [15:0] addr;
        logic [15:0] value;
    } mwd_par_req_t;

    typedef struct packed {
        logic ack;
        logic locked;
    } mwd_par_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HDR   = 3'b001,
        ST_BCNT  = 3'b010,
        ST_DATA  = 3'b011,
        ST_WAIT  = 3'b100,
        ST_DRAIN = 3'b101,
        ST_RESP  = 3'b110,
        ST_SEND  = 3'b111
    } mwd_state_t;

endpackage : mwd_pkg

// >>> src/mwd_err_cnt.sv
// Saturating communication error counter with remote clear.
// Assumes event and clear pulses from logic on the same clock.
module mwd_err_cnt (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_event,
    input  wire logic        i_clear,
    output logic      [15:0] o_count
);
    import mwd_pkg::*;

    // RL8 counter with clear
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_count <= CNT_RESET;
        end else if (i_clear) begin
            // An error landing on the clear cycle is still counted
            o_count <= i_event ? 16'h0001 : CNT_RESET;
        end else if (i_event && o_count != CNT_TOP) begin
            o_count <= o_count + 16'h0001;
        end
    end

endmodule : mwd_err_cnt

// >>> src/mwd_tx_ser.sv
// Response serializer: loads up to five bytes and shifts them out first byte first.
// Assumes the load pulse comes only while idle.
module mwd_tx_ser (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_srst,
    input  wire logic                 i_load,
    input  wire logic [2:0]           i_len,
    input  wire logic [4:0][7:0]      i_bytes,
    input  wire logic                 i_tx_ready,
    output mwd_pkg::mwd_byte_t        o_tx,
    output logic                      o_done
);
    import mwd_pkg::*;

    logic [3:0][7:0] rest;
    logic [2:0]      left;

    // RL16 high byte leaves first
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_tx   <= '0;
            rest   <= '0;
            left   <= 3'h0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_load) begin
                o_tx.valid <= 1'b1;
                o_tx.last  <= (i_len == 3'h1);
                o_tx.data  <= i_bytes[0];
                rest       <= i_bytes[4:1];
                left       <= i_len;
            end else if (o_tx.valid && i_tx_ready) begin
                if (o_tx.last) begin
                    o_tx.valid <= 1'b0;
                    o_tx.last  <= 1'b0;
                    o_done     <= 1'b1;
                end else begin
                    o_tx.data <= rest[0];
                    o_tx.last <= (left == 3'h2);
                    rest      <= {8'h00, rest[3:1]};
                    left      <= left - 3'h1;
                end
            end
        end
    end

endmodule : mwd_tx_ser

// >>> src/mwd_handler.sv
// Request handler for the single write, RAM-only write, multi write and diagnosis PDUs.
// Assumes a framing layer delivering PDU bytes with a last marker, a parameter store
// that acknowledges each write and reports stop-only parameters, and a response sink.
module mwd_handler (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_srst,
    input  wire mwd_pkg::mwd_byte_t    i_rx,
    output logic                       o_rx_ready,
    output mwd_pkg::mwd_byte_t         o_tx,
    input  wire logic                  i_tx_ready,
    output mwd_pkg::mwd_par_req_t      o_par_req,
    input  wire mwd_pkg::mwd_par_rsp_t i_par_rsp,
    input  wire logic                  i_comm_err,
    output logic                [15:0] o_err_count
);
    import mwd_pkg::*;

    mwd_state_t      state;
    mwd_state_t      next_state;
    logic [7:0]      func;
    logic [3:0][7:0] hdr;
    logic [4:0]      cnt;
    logic [4:0]      idx;
    logic [7:0]      hi;
    logic            ended;
    logic            err_on;
    logic [7:0]      exc;
    logic [7:0]      next_exc;
    logic            set_err;
    logic            issue_wr;
    logic            diag_clr;
    logic            take;
    logic            is_multi;
    logic [15:0]     nreg;
    logic [15:0]     sub_fn;
    logic            cnt_ok;
    logic            known;
    logic            tx_load;
    logic            tx_done;
    logic [2:0]      tx_len;
    logic [4:0][7:0] tx_bytes;

    assign take     = i_rx.valid && o_rx_ready;
    assign is_multi = (func == FN_WR_MULTI);
    assign nreg     = {hdr[2], hdr[3]};
    // RL5 sub-function sits in the first header pair
    assign sub_fn   = {hdr[0], hdr[1]};
    assign known    = (i_rx.data == FN_WR_SAVE) || (i_rx.data == FN_DIAG)
                   || (i_rx.data == FN_WR_RAM) || (i_rx.data == FN_WR_MULTI);
    // RL2 byte count must be twice the register count
    assign cnt_ok   = (nreg >= REG_MIN) && (nreg <= REG_MAX)
                   && ({8'h00, i_rx.data} == {nreg[14:0], 1'b0});

    always_comb begin
        next_state = state;
        next_exc   = exc;
        set_err    = 1'b0;
        issue_wr   = 1'b0;
        diag_clr   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    if (!known) begin
                        set_err    = 1'b1;
                        next_exc   = EXC_FUNC;
                        next_state = i_rx.last ? ST_RESP : ST_DRAIN;
                    end else if (i_rx.last) begin
                        set_err    = 1'b1;
                        next_exc   = EXC_DATA;
                        next_state = ST_RESP;
                    end else begin
                        next_state = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (take) begin
                    if (cnt[2:0] != HDR_LAST) begin
                        if (i_rx.last) begin
                            set_err    = 1'b1;
                            next_exc   = EXC_DATA;
                            next_state = ST_RESP;
                        end
                    end else if (is_multi) begin
                        if (i_rx.last) begin
                            set_err    = 1'b1;
                            next_exc   = EXC_DATA;
                            next_state = ST_RESP;
                        end else begin
                            next_state = ST_BCNT;
                        end
                    end else if (!i_rx.last) begin
                        set_err    = 1'b1;
                        next_exc   = EXC_DATA;
                        next_state = ST_DRAIN;
                    end else if (func == FN_DIAG) begin
                        // RL6 diagnosis never reaches the parameter port
                        // RL7 echo of the request
                        if (sub_fn == DIAG_ECHO) begin
                            next_state = ST_RESP;
                        // RL8 remote clear of the counter
                        end else if (sub_fn == DIAG_CLR_CNT) begin
                            diag_clr   = 1'b1;
                            next_state = ST_RESP;
                        end else begin
                            set_err    = 1'b1;
                            next_exc   = EXC_FUNC;
                            next_state = ST_RESP;
                        end
                    end else begin
                        // RL9 single write issued
                        issue_wr   = 1'b1;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_BCNT: begin
                if (take) begin
                    // RL17 bad counts refused before any write
                    if (!cnt_ok || i_rx.last) begin
                        set_err    = 1'b1;
                        next_exc   = EXC_DATA;
                        next_state = i_rx.last ? ST_RESP : ST_DRAIN;
                    end else begin
                        next_state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (take) begin
                    if (!cnt[0]) begin
                        if (i_rx.last) begin
                            set_err    = 1'b1;
                            next_exc   = EXC_DATA;
                            next_state = ST_RESP;
                        end
                    end else begin
                        // RL1 one register per value pair
                        issue_wr   = 1'b1;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (i_par_rsp.ack) begin
                    // RL4 stop-only parameter refused
                    if (i_par_rsp.locked) begin
                        set_err    = 1'b1;
                        next_exc   = EXC_FUNC;
                        next_state = ended ? ST_RESP : ST_DRAIN;
                    end else if (is_multi && ({11'h000, idx} != nreg - 16'h0001)) begin
                        if (ended) begin
                            set_err    = 1'b1;
                            next_exc   = EXC_DATA;
                            next_state = ST_RESP;
                        end else begin
                            next_state = ST_DATA;
                        end
                    // RL10 answer only after the store acknowledged
                    end else if (ended) begin
                        next_state = ST_RESP;
                    end else begin
                        set_err    = 1'b1;
                        next_exc   = EXC_DATA;
                        next_state = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                if (take && i_rx.last) begin
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                next_state = ST_SEND;
            end
            ST_SEND: begin
                if (tx_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state      <= ST_IDLE;
            o_rx_ready <= 1'b0;
        end else begin
            state      <= next_state;
            // Stall the framing layer while a write or an answer is in flight
            o_rx_ready <= (next_state == ST_IDLE) || (next_state == ST_HDR)
                       || (next_state == ST_BCNT) || (next_state == ST_DATA)
                       || (next_state == ST_DRAIN);
        end
    end

    // RL16 fields assembled high byte first
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            func  <= 8'h00;
            hdr   <= '0;
            cnt   <= 5'h00;
            hi    <= 8'h00;
            ended <= 1'b0;
        end else if (take) begin
            ended <= i_rx.last;
            case (state)
                ST_IDLE: begin
                    func <= i_rx.data;
                    cnt  <= 5'h00;
                end
                ST_HDR: begin
                    hdr[cnt[1:0]] <= i_rx.data;
                    cnt           <= cnt + 5'h01;
                end
                ST_BCNT: begin
                    cnt <= 5'h00;
                end
                ST_DATA: begin
                    if (!cnt[0]) begin
                        hi <= i_rx.data;
                    end
                    cnt <= cnt + 5'h01;
                end
                default: begin
                    cnt <= cnt;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            idx <= 5'h00;
        end else if (take && state == ST_IDLE) begin
            idx <= 5'h00;
        end else if (state == ST_WAIT && i_par_rsp.ack) begin
            idx <= idx + 5'h01;
        end
    end

    // RL15 first failure picks the exception code
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            err_on <= 1'b0;
            exc    <= 8'h00;
        end else if (set_err) begin
            err_on <= 1'b1;
            exc    <= next_exc;
        end else if (take && state == ST_IDLE) begin
            err_on <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_par_req <= '0;
        end else if (issue_wr) begin
            o_par_req.valid <= 1'b1;
            // RL12 only the saving code asks for the non-volatile copy
            // RL13 RAM copy acts at once
            o_par_req.save  <= (func == FN_WR_SAVE);
            if (is_multi) begin
                o_par_req.addr  <= sub_fn + {11'h000, idx};
                o_par_req.value <= {hi, i_rx.data};
            end else begin
                o_par_req.addr  <= sub_fn;
                o_par_req.value <= {hdr[2], i_rx.data};
            end
        end else if (i_par_rsp.ack) begin
            o_par_req.valid <= 1'b0;
        end
    end

    // RL3 header echo without values
    // RL15 error answer is function plus flag and the code
    always_comb begin
        if (err_on) begin
            tx_len   = RSP_LEN_ERR;
            tx_bytes = {24'h000000, exc, func | FN_ERR_FLAG};
        end else begin
            tx_len   = RSP_LEN_OK;
            tx_bytes = {hdr[3], hdr[2], hdr[1], hdr[0], func};
        end
    end

    assign tx_load = (state == ST_RESP);

    mwd_tx_ser u_tx_ser (
        .i_clk_sys  (i_clk_sys),
        .i_srst     (i_srst),
        .i_load     (tx_load),
        .i_len      (tx_len),
        .i_bytes    (tx_bytes),
        .i_tx_ready (i_tx_ready),
        .o_tx       (o_tx),
        .o_done     (tx_done)
    );

    mwd_err_cnt u_err_cnt (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_event   (i_comm_err),
        .i_clear   (diag_clr),
        .o_count   (o_err_count)
    );

endmodule : mwd_handler

// >>> test/mwd_handler_monitor.sv
// Port checker for the write/diagnosis handler, bound into every handler instance.
// Assumes one clock domain with a synchronous active-high reset.
module mwd_handler_monitor (
    input wire logic                  i_clk_sys,
    input wire logic                  i_srst,
    input wire logic                  o_rx_ready,
    input wire mwd_pkg::mwd_byte_t    o_tx,
    input wire logic                  i_tx_ready,
    input wire mwd_pkg::mwd_par_req_t o_par_req,
    input wire mwd_pkg::mwd_par_rsp_t i_par_rsp,
    input wire logic                  i_comm_err,
    input wire logic [15:0]           o_err_count
);
    timeunit 1ns;
    timeprecision 1ps;
    import mwd_pkg::*;
    logic [2:0] tx_cnt;
    logic       first_err;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    // Position in the response frame; error frames are two bytes long
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_cnt <= 3'h0;
        end else if (o_tx.valid && i_tx_ready) begin
            tx_cnt <= o_tx.last ? 3'h0 : tx_cnt + 3'h1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            first_err <= 1'b0;
        end else if (o_tx.valid && i_tx_ready && tx_cnt == 3'h0) begin
            first_err <= o_tx.data[7];
        end
    end

    sequence s_par_done;
        o_par_req.valid && i_par_rsp.ack;
    endsequence
    sequence s_save_ok;
        s_par_done ##0 (o_par_req.save && !i_par_rsp.locked);
    endsequence

    chk_par_hold:
        assert property (o_par_req.valid && !i_par_rsp.ack |=> $stable(o_par_req))
        else $error("write request changed before ack");
    chk_par_drop:
        assert property (s_par_done |=> !o_par_req.valid)
        else $error("write request held after ack");
    chk_rx_block:
        assert property (o_par_req.valid |-> !o_rx_ready)
        else $error("bytes taken during a write");
    chk_rsp_after:
        assert property ($rose(o_tx.valid) |-> !o_par_req.valid)
        else $error("response started with a write pending");
    chk_save_echo:
        assert property (s_save_ok |-> ##2 (o_tx.valid && o_tx.data == FN_WR_SAVE))
        else $error("single write answer late or wrong");
    chk_tx_hold:
        assert property (o_tx.valid && !i_tx_ready |=> $stable(o_tx))
        else $error("response byte changed while stalled");
    chk_tx_len:
        assert property (o_tx.valid && o_tx.last |-> tx_cnt == (first_err ? 3'h1 : 3'h4))
        else $error("response length wrong");
    chk_err_count:
        assert property (i_comm_err && o_err_count != CNT_TOP
                         |=> o_err_count == $past(o_err_count) + 16'h0001 || o_err_count == 16'h0001)
        else $error("error counter missed an event");
endmodule : mwd_handler_monitor

bind mwd_handler mwd_handler_monitor u_mwd_handler_monitor (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .o_rx_ready  (o_rx_ready),
    .o_tx        (o_tx),
    .i_tx_ready  (i_tx_ready),
    .o_par_req   (o_par_req),
    .i_par_rsp   (i_par_rsp),
    .i_comm_err  (i_comm_err),
    .o_err_count (o_err_count)
);

// >>> test/mwd_master_model.sv
// Master-side model: sends request frames byte by byte and collects answer bytes.
// Assumes the bench calls send_frame just after a rising edge and reads rsp.
module mwd_master_model (
    input  wire logic               i_clk_sys,
    output mwd_pkg::mwd_byte_t      o_rx,
    input  wire logic               i_rx_ready,
    input  wire mwd_pkg::mwd_byte_t i_tx,
    output logic                    o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import mwd_pkg::*;
    logic [7:0] rsp[$];

    initial begin
        o_rx = '0;
        o_tx_ready = 1'b0;
    end

    task automatic send_frame(input logic [7:0] f[$]);
        foreach (f[i]) begin
            o_rx = '{valid: 1'b1, last: (i == f.size() - 1), data: f[i]};
            @(negedge i_clk_sys);
            while (i_rx_ready !== 1'b1) @(negedge i_clk_sys);
            @(posedge i_clk_sys);
            #1;
        end
        // Released line shows the inverse, so a stale byte cannot pass
        o_rx = '{valid: 1'b0, last: 1'b0, data: ~o_rx.data};
    endtask : send_frame

    // Sink stalls about a third of the time
    always @(posedge i_clk_sys) begin
        #1;
        o_tx_ready = ($urandom_range(0, 2) != 0);
    end
    always @(negedge i_clk_sys) begin
        if (i_tx.valid === 1'b1 && o_tx_ready === 1'b1) rsp.push_back(i_tx.data);
    end
endmodule : mwd_master_model

// >>> test/mwd_handler_tb.sv
// Self-checking bench for the write/diagnosis handler against a queue-based reference.
// Assumes the master model drives requests; the bench plays the parameter store.
module mwd_handler_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mwd_pkg::*;
    logic         i_clk_sys;
    logic         i_srst;
    mwd_byte_t    rx;
    logic         rx_ready;
    mwd_byte_t    tx;
    logic         tx_ready;
    mwd_par_req_t par_req;
    mwd_par_rsp_t par_rsp;
    logic         comm_err;
    logic [15:0]  err_count;
    int           fails = 0;
    int           n_tests = 0;
    int           cycles = 0;
    int           cm = 0;
    logic [32:0]  got_w[$];
    logic [32:0]  exp_w[$];
    logic [7:0]   exp_r[$];
    logic [7:0]   fr[$];

    mwd_handler u_mwd_handler (
        .i_clk_sys   (i_clk_sys),
        .i_srst      (i_srst),
        .i_rx        (rx),
        .o_rx_ready  (rx_ready),
        .o_tx        (tx),
        .i_tx_ready  (tx_ready),
        .o_par_req   (par_req),
        .i_par_rsp   (par_rsp),
        .i_comm_err  (comm_err),
        .o_err_count (err_count)
    );
    mwd_master_model u_mwd_master_model (
        .i_clk_sys  (i_clk_sys),
        .o_rx       (rx),
        .i_rx_ready (rx_ready),
        .i_tx       (tx),
        .o_tx_ready (tx_ready)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // Stop-only parameters sit at addresses ee00..eeff
    function automatic logic lk(input logic [15:0] a);
        return a[15:8] == 8'hee;
    endfunction : lk

    initial begin
        par_rsp = '0;
        forever begin
            @(negedge i_clk_sys);
            if (par_req.valid === 1'b1) begin
                repeat ($urandom_range(1, 4)) @(posedge i_clk_sys);
                #1;
                par_rsp = '{ack: 1'b1, locked: lk(par_req.addr)};
                if (!lk(par_req.addr)) got_w.push_back({par_req.save, par_req.addr, par_req.value});
                @(posedge i_clk_sys);
                #1;
                par_rsp = '0;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic model(input logic [7:0] f[$]);
        logic [15:0] a;
        logic [15:0] v;
        logic [7:0]  e;
        a = {f[1], f[2]};
        v = {f[3], f[4]};
        e = 8'h00;
        exp_w.delete();
        exp_r = f[0:4];
        case (f[0])
            FN_WR_SAVE, FN_WR_RAM: begin
                // Extra bytes are refused before the single write is issued
                if (f.size() != 5) e = EXC_DATA;
                else if (lk(a)) e = EXC_FUNC;
                else exp_w.push_back({f[0] == FN_WR_SAVE, a, v});
            end
            FN_DIAG: begin
                if (a == DIAG_CLR_CNT) cm = 0;
                else if (a != DIAG_ECHO) e = EXC_FUNC;
            end
            FN_WR_MULTI: begin
                if (v < REG_MIN || v > REG_MAX || {8'h00, f[5]} != v << 1) e = EXC_DATA;
                for (int i = 0; i < v && e == 8'h00; i++) begin
                    if (lk(a + 16'(i))) e = EXC_FUNC;
                    else exp_w.push_back({1'b0, a + 16'(i), f[6 + 2 * i], f[7 + 2 * i]});
                end
                if (e == 8'h00 && f.size() != 6 + 2 * v) e = EXC_DATA;
            end
            default: e = EXC_FUNC;
        endcase
        if (e != 8'h00) exp_r = {f[0] | FN_ERR_FLAG, e};
    endtask : model

    task automatic run(input logic [7:0] f[$]);
        int k;
        model(f);
        got_w.delete();
        u_mwd_master_model.rsp.delete();
        u_mwd_master_model.send_frame(f);
        for (k = 0; k < 500 && u_mwd_master_model.rsp.size() < exp_r.size(); k++)
            @(posedge i_clk_sys);
        // Extra cycles expose surplus answer bytes
        repeat (4) @(posedge i_clk_sys);
        #1;
        check(33'(u_mwd_master_model.rsp.size()), 33'(exp_r.size()));
        foreach (exp_r[i]) check(33'(u_mwd_master_model.rsp[i]), 33'(exp_r[i]));
        check(33'(got_w.size()), 33'(exp_w.size()));
        foreach (exp_w[i]) check(got_w[i], exp_w[i]);
        check(33'(err_count), 33'(cm));
    endtask : run

    task automatic wr(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] v);
        fr = {fn, a[15:8], a[7:0], v[15:8], v[7:0]};
        run(fr);
    endtask : wr

    task automatic mw(input logic [15:0] a, input logic [15:0] n, input logic [7:0] bc,
                      input int nb);
        fr = {FN_WR_MULTI, a[15:8], a[7:0], n[15:8], n[7:0], bc};
        repeat (nb) fr.push_back(8'($urandom));
        run(fr);
    endtask : mw

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        void'($urandom(51));
        i_srst = 1'b1;
        comm_err = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_srst = 1'b0;
        for (int i = 0; i < 6; i++)
            wr(i[0] ? FN_WR_RAM : FN_WR_SAVE, 16'($urandom_range(0, 16'hedff)), 16'($urandom));
        wr(FN_WR_SAVE, 16'hee01, 16'h1234);
        wr(FN_WR_RAM, 16'hee02, 16'h0001);
        // an often-changed value goes through the RAM-only write
        repeat (2) wr(FN_WR_RAM, 16'h0007, 16'($urandom));
        mw(16'h000e, 16'h0002, 8'h04, 4);
        mw(16'h0100, 16'h0001, 8'h02, 2);
        mw(16'h0200, 16'h0010, 8'h20, 32);
        mw(16'h0300, 16'h0000, 8'h00, 0);
        mw(16'h0300, 16'h0011, 8'h22, 34);
        mw(16'h0300, 16'h0002, 8'h05, 4);
        mw(16'hedfe, 16'h0004, 8'h08, 8);
        wr(FN_DIAG, DIAG_ECHO, 16'ha537);
        wr(FN_DIAG, DIAG_ECHO, 16'($urandom));
        wr(FN_DIAG, 16'h0001, 16'h0000);
        wr(8'h03, 16'h0000, 16'h0001);
        wr(8'h10, 16'h0000, 16'h0001);
        repeat ($urandom_range(1, 5)) begin
            comm_err = 1'b1;
            cm++;
            @(posedge i_clk_sys);
            #1;
            comm_err = 1'b0;
            @(posedge i_clk_sys);
            #1;
        end
        wr(FN_DIAG, DIAG_ECHO, 16'h0000);
        wr(FN_DIAG, DIAG_CLR_CNT, 16'h1234);
        fr = {FN_WR_SAVE, 8'h00, 8'h07, 8'h13, 8'h88, 8'h00};
        run(fr);
        fr = {FN_WR_RAM, 8'h00, 8'h07};
        run(fr);
        finish_test();
    end
endmodule : mwd_handler_tb
